// ==== design/dfc_pkg.sv ====
// Purpose: constants for the synthesizer function-control register bank
// Assumes: one 200 MHz system clock, synchronous active-low reset
// Notes: offsets are register indices on the plain register port
package dfc_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] GLOBAL_OFS = 8'h02;
  localparam logic [7:0] CHAN_OFS = 8'h03;
  localparam logic [7:0] SELECT_OFS = 8'h00; // channel select, 4 bits
  localparam logic [7:0] UPDATE_OFS = 8'h10; // write any value: update
  localparam logic [7:0] STATUS_OFS = 8'h11; // live reload, no-dwell and hold flags
  localparam int NCH = 4;
  localparam int GLOBAL_W = 16;
  localparam int CHAN_W = 24;
  localparam int ACC_W = 32;
  localparam int RATE_W = 8;
  // ----------------------------------------------------------------------
  // global register fields
  // ----------------------------------------------------------------------
  localparam int G_AUTO_SWEEP = 15;
  localparam int G_CLR_SWEEP = 14;
  localparam int G_AUTO_PHASE = 13;
  localparam int G_CLR_PHASE = 12;
  localparam int G_AUTOSYNC = 7;
  localparam int G_SYNCMASTER = 6;
  localparam int G_SYNCSTATUS = 5;
  localparam int G_SYNCMASK = 4;
  localparam logic [15:0] GLOBAL_MASK = 16'hF0F3;
  localparam logic [15:0] GLOBAL_RST = 16'h0000;
  // ----------------------------------------------------------------------
  // channel register fields
  // ----------------------------------------------------------------------
  localparam int C_MOD_HI = 23;
  localparam int C_MOD_LO = 22;
  localparam int C_NODWELL = 15;
  localparam int C_SWEEP_EN = 14;
  localparam int C_LOAD_RATE = 13;
  localparam int C_FS_HI = 9;
  localparam int C_FS_LO = 8;
  localparam int C_DIG_PD = 7;
  localparam int C_DAC_PD = 6;
  localparam int C_MATCHED = 5;
  localparam int C_AUTO_SWEEP = 4;
  localparam int C_CLR_SWEEP = 3;
  localparam int C_AUTO_PHASE = 2;
  localparam int C_CLR_PHASE = 1;
  localparam int C_SINE = 0;
  // bit 10 must be zero, 21:16 and 12:11 unused
  localparam logic [23:0] CHAN_MASK = 24'hC0E3FF;
  localparam logic [23:0] CHAN_RST = 24'h000300;
  localparam logic [ACC_W-1:0] ACC_ZERO = 32'h00000000;
  localparam logic [RATE_W-1:0] TIMER_ONE = 8'h01;
  localparam int MATCH_DEPTH = 2; // equalising stages for matched mode
endpackage : dfc_pkg

// ==== design/dfc_channel_control.sv ====
// Purpose: global and per-channel function registers of a 4-channel DDS
// Assumes: host writes take effect at once; a write to the update offset only strobes autoclears and timer reloads
// Notes: accumulators here are a minimal core model steered by the bits
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Contract
// - global bit 15 set: update zeroes all sweep accumulators one cycle
// - global bit 15 clear: new delta only reaches accumulator input
// - global bit 14 set: all sweep accumulators held clear
// - global bit 13 set: update zeroes all phase accumulators one cycle
// - global bit 12 set: all phase accumulators held clear
// - global holds sync fields at 7,6,5,4 and 1:0; 11:8,3:2 unused
// - channel bits 23:22 select modulated quantity; 21:16 unused
// - bit 15 gives no-dwell sweep only while bit 14 set
// - bit 14 adds delta into frequency accumulator at ramp rate
// - ramp timer reloads at count one, or on update if bit 13
// - bits 9:8 are DAC full-scale code, reset to 11
// - bit 7 powers down the channel digital core
// - bit 6 powers down the channel DAC
// - bit 5 enables matched pipeline delays
// - bit 4: update clears this channel's sweep accumulator one cycle
// - bit 3: this channel's sweep accumulator held clear
// - bit 2: update clears this channel's phase accumulator one cycle
// - bit 1: this channel's phase accumulator held clear
// - bit 0 selects sine when set, cosine when clear
// - channel register at 0x03, 24 bits, bit 10 forced zero
// - global register at 0x02, 16 bits wide
module dfc_channel_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dfc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [dfc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [dfc_pkg::DATA_W-1:0] regRdata,
  input wire logic [dfc_pkg::ACC_W-1:0] deltaWord,
  input wire logic [dfc_pkg::ACC_W-1:0] tuningWord,
  input wire logic [dfc_pkg::RATE_W-1:0] sweepRampRate,
  output logic [dfc_pkg::NCH*dfc_pkg::ACC_W-1:0] phaseAcc,
  output logic [dfc_pkg::NCH*dfc_pkg::ACC_W-1:0] sweepAcc,
  output logic [dfc_pkg::NCH*2-1:0] modulationQuantitySelect,
  output logic [dfc_pkg::NCH*2-1:0] dacFullScale,
  output logic [dfc_pkg::NCH-1:0] digitalPowerDown,
  output logic [dfc_pkg::NCH-1:0] dacPowerDown,
  output logic [dfc_pkg::NCH-1:0] matchedDelay,
  output logic [dfc_pkg::NCH-1:0] sineSelect,
  output logic [dfc_pkg::NCH-1:0] noDwellActive,
  output logic [7:0] syncControl
);
  localparam int N = dfc_pkg::NCH;
  localparam int AW = dfc_pkg::ACC_W;

  logic [dfc_pkg::GLOBAL_W-1:0] global_reg;
  logic [dfc_pkg::CHAN_W-1:0] chan_reg [N];
  logic [N-1:0] chanSel_reg;
  logic ioUpdate;
  logic [AW-1:0] phase_reg [N];
  logic [AW-1:0] sweep_reg [N];
  logic [dfc_pkg::RATE_W-1:0] timer_reg [N];
  logic [AW-1:0] tuneDly_reg [dfc_pkg::MATCH_DEPTH];
  logic [N-1:0] sweepHold;
  logic [N-1:0] phaseHold;
  logic [N-1:0] sweepZero;
  logic [N-1:0] phaseZero;
  logic [N-1:0] timerReload;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // update strobe is a write to its own offset, one cycle wide
  assign ioUpdate = regWr && (regAddr == dfc_pkg::UPDATE_OFS);

  // global register; unused bits never store so they read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_reg <= dfc_pkg::GLOBAL_RST;
    end else if (regWr && regAddr == dfc_pkg::GLOBAL_OFS) begin
      global_reg <= regWdata[15:0] & dfc_pkg::GLOBAL_MASK;
    end
  end

  // channel select picks which channel copies take a channel write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chanSel_reg <= {N{1'b1}};
    end else if (regWr && regAddr == dfc_pkg::SELECT_OFS) begin
      chanSel_reg <= regWdata[N-1:0];
    end
  end

  // per-channel function registers; bit 10 is masked to keep it zero
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_n) begin
        chan_reg[i] <= dfc_pkg::CHAN_RST;
      end else if (regWr && regAddr == dfc_pkg::CHAN_OFS
                   && chanSel_reg[i]) begin
        chan_reg[i] <= regWdata[23:0] & dfc_pkg::CHAN_MASK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  // channel readback uses the lowest selected channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      if (regAddr == dfc_pkg::GLOBAL_OFS) begin
        regRdata <= {16'h0000, global_reg};
      end else if (regAddr == dfc_pkg::CHAN_OFS) begin
        regRdata <= 32'h00000000;
        for (int i = N - 1; i >= 0; i--) begin
          if (chanSel_reg[i]) regRdata <= {8'h00, chan_reg[i]};
        end
      end else if (regAddr == dfc_pkg::SELECT_OFS) begin
        regRdata <= {28'h0000000, chanSel_reg};
      end else if (regAddr == dfc_pkg::STATUS_OFS) begin
        regRdata <= {16'h0000, timerReload, noDwellActive,
                     sweepHold, phaseHold};
      end else begin
        regRdata <= 32'h00000000; // unmapped reads zero
      end
    end
  end

  // ----------------------------------------------------------------------
  // clear decode
  // ----------------------------------------------------------------------
  // held clears win over everything; strobed clears last one cycle
  always_comb begin
    for (int i = 0; i < N; i++) begin
      sweepHold[i] = global_reg[dfc_pkg::G_CLR_SWEEP]
                     || chan_reg[i][dfc_pkg::C_CLR_SWEEP];
      phaseHold[i] = global_reg[dfc_pkg::G_CLR_PHASE]
                     || chan_reg[i][dfc_pkg::C_CLR_PHASE];
      sweepZero[i] = ioUpdate && (global_reg[dfc_pkg::G_AUTO_SWEEP]
                     || chan_reg[i][dfc_pkg::C_AUTO_SWEEP]);
      phaseZero[i] = ioUpdate && (global_reg[dfc_pkg::G_AUTO_PHASE]
                     || chan_reg[i][dfc_pkg::C_AUTO_PHASE]);
      timerReload[i] = (timer_reg[i] == dfc_pkg::TIMER_ONE)
                       || (ioUpdate && chan_reg[i][dfc_pkg::C_LOAD_RATE]);
    end
  end

  // ----------------------------------------------------------------------
  // ramp-rate timers
  // ----------------------------------------------------------------------
  // reload at one, or on update when enabled
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_n) begin
        timer_reg[i] <= dfc_pkg::TIMER_ONE;
      end else if (timerReload[i]) begin
        timer_reg[i] <= sweepRampRate;
      end else if (timer_reg[i] != '0) begin
        timer_reg[i] <= timer_reg[i] - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sweep accumulators
  // ----------------------------------------------------------------------
  // delta only added on a timer tick; otherwise just sits at the input
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_n || sweepHold[i]) begin
        sweep_reg[i] <= dfc_pkg::ACC_ZERO;
      end else if (sweepZero[i]) begin
        sweep_reg[i] <= dfc_pkg::ACC_ZERO;
      end else if (chan_reg[i][dfc_pkg::C_SWEEP_EN]
                   && !chan_reg[i][dfc_pkg::C_DIG_PD]
                   && timer_reg[i] == dfc_pkg::TIMER_ONE) begin
        sweep_reg[i] <= sweep_reg[i] + deltaWord;
      end
    end
  end

  // ----------------------------------------------------------------------
  // phase accumulators
  // ----------------------------------------------------------------------
  // matched mode delays the tuning word to line up with other paths
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < dfc_pkg::MATCH_DEPTH; k++) tuneDly_reg[k] <= '0;
    end else begin
      tuneDly_reg[0] <= tuningWord;
      for (int k = 1; k < dfc_pkg::MATCH_DEPTH; k++)
        tuneDly_reg[k] <= tuneDly_reg[k-1];
    end
  end

  // step is tuning plus sweep offset; power-down freezes the core
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_n || phaseHold[i]) begin
        phase_reg[i] <= dfc_pkg::ACC_ZERO;
      end else if (phaseZero[i]) begin
        phase_reg[i] <= dfc_pkg::ACC_ZERO;
      end else if (!chan_reg[i][dfc_pkg::C_DIG_PD]) begin
        phase_reg[i] <= phase_reg[i] + sweep_reg[i]
          + (chan_reg[i][dfc_pkg::C_MATCHED]
             ? tuneDly_reg[dfc_pkg::MATCH_DEPTH-1] : tuningWord);
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  // all control outputs registered so they come straight from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phaseAcc <= '0;
      sweepAcc <= '0;
      modulationQuantitySelect <= '0;
      dacFullScale <= {N{2'b11}};
      digitalPowerDown <= '0;
      dacPowerDown <= '0;
      matchedDelay <= '0;
      sineSelect <= '0;
      noDwellActive <= '0;
      syncControl <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        phaseAcc[i*AW +: AW] <= phase_reg[i];
        sweepAcc[i*AW +: AW] <= sweep_reg[i];
        modulationQuantitySelect[i*2 +: 2] <=
          chan_reg[i][dfc_pkg::C_MOD_HI:dfc_pkg::C_MOD_LO];
        dacFullScale[i*2 +: 2] <=
          chan_reg[i][dfc_pkg::C_FS_HI:dfc_pkg::C_FS_LO];
        digitalPowerDown[i] <= chan_reg[i][dfc_pkg::C_DIG_PD];
        dacPowerDown[i] <= chan_reg[i][dfc_pkg::C_DAC_PD];
        matchedDelay[i] <= chan_reg[i][dfc_pkg::C_MATCHED];
        sineSelect[i] <= chan_reg[i][dfc_pkg::C_SINE];
        noDwellActive[i] <= chan_reg[i][dfc_pkg::C_NODWELL]
                            && chan_reg[i][dfc_pkg::C_SWEEP_EN];
      end
      syncControl <= global_reg[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // strobed clears: zero on the edge after the strobe, then run again
  a_global_sweep_auto: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ioUpdate && global_reg[dfc_pkg::G_AUTO_SWEEP])
    |=> sweep_reg[0] == '0 && sweep_reg[3] == '0)
    else $error("global sweep autoclear missed");
  a_global_phase_auto: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ioUpdate && global_reg[dfc_pkg::G_AUTO_PHASE])
    |=> phase_reg[2] == '0)
    else $error("global phase autoclear missed");
  a_chan_sweep_auto: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ioUpdate && chan_reg[2][dfc_pkg::C_AUTO_SWEEP])
    |=> sweep_reg[2] == '0)
    else $error("channel sweep autoclear missed");
  a_chan_phase_auto: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ioUpdate && chan_reg[1][dfc_pkg::C_AUTO_PHASE])
    |=> phase_reg[1] == '0)
    else $error("channel phase autoclear missed");
  // without an autoclear the strobe may not load anything by itself
  a_sweep_no_force: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ioUpdate && !sweepZero[0] && !sweepHold[0])
    |=> (sweep_reg[0] == $past(sweep_reg[0])
    || sweep_reg[0] == $past(sweep_reg[0]) + $past(deltaWord)))
    else $error("sweep accumulator forced by update");

  // held clears: zero for as long as the bit stays set
  a_global_sweep_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    global_reg[dfc_pkg::G_CLR_SWEEP] [*2] |-> sweep_reg[1] == '0)
    else $error("global sweep clear not held");
  a_global_phase_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    global_reg[dfc_pkg::G_CLR_PHASE] |=> phase_reg[0] == '0)
    else $error("global phase clear not held");
  a_chan_sweep_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    chan_reg[1][dfc_pkg::C_CLR_SWEEP] |=> sweep_reg[1] == '0)
    else $error("channel sweep clear not held");
  a_chan_phase_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    chan_reg[3][dfc_pkg::C_CLR_PHASE] |=> phase_reg[3] == '0)
    else $error("channel phase clear not held");
  // first step after a held clear starts again from zero
  a_phase_resume: assert property (
    @(posedge clk) disable iff (!rst_n)
    phaseHold[0] ##1 (!phaseHold[0] && !phaseZero[0]
    && !chan_reg[0][dfc_pkg::C_DIG_PD] && !chan_reg[0][dfc_pkg::C_MATCHED])
    |=> phase_reg[0] == $past(sweep_reg[0]) + $past(tuningWord))
    else $error("phase did not resume after clear");

  // sweep gating and the ramp-rate timer
  a_sweep_frozen: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!chan_reg[0][dfc_pkg::C_SWEEP_EN] && !sweepZero[0])
    |=> sweep_reg[0] == '0 || $stable(sweep_reg[0]))
    else $error("sweep moved while disabled");
  a_timer_reload: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ioUpdate && chan_reg[0][dfc_pkg::C_LOAD_RATE])
    |=> timer_reg[0] == $past(sweepRampRate))
    else $error("ramp timer not reloaded");
  a_timer_tick: assert property (
    @(posedge clk) disable iff (!rst_n)
    timer_reg[0] == dfc_pkg::TIMER_ONE
    |=> timer_reg[0] == $past(sweepRampRate))
    else $error("ramp timer not reloaded at one");
  a_timer_count: assert property (
    @(posedge clk) disable iff (!rst_n)
    (timer_reg[0] > dfc_pkg::TIMER_ONE
    && !(ioUpdate && chan_reg[0][dfc_pkg::C_LOAD_RATE]))
    |=> timer_reg[0] == $past(timer_reg[0]) - dfc_pkg::TIMER_ONE)
    else $error("ramp timer did not count down");
  a_nodwell_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    !chan_reg[0][dfc_pkg::C_SWEEP_EN] |=> !noDwellActive[0])
    else $error("no-dwell active without sweep");
  // power-down stops both accumulators; clears still reach them
  a_core_frozen: assert property (
    @(posedge clk) disable iff (!rst_n)
    (chan_reg[1][dfc_pkg::C_DIG_PD] && !phaseHold[1] && !phaseZero[1])
    |=> $stable(phase_reg[1]))
    else $error("phase moved while powered down");
  a_sweep_pd_frozen: assert property (
    @(posedge clk) disable iff (!rst_n)
    (chan_reg[2][dfc_pkg::C_DIG_PD] && !sweepHold[2] && !sweepZero[2])
    |=> $stable(sweep_reg[2]))
    else $error("sweep moved while powered down");

  // register fields and the outputs that follow them by one edge
  a_bit10_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    chan_reg[1][10] == 1'b0)
    else $error("channel bit 10 not zero");
  a_global_unused: assert property (
    @(posedge clk) disable iff (!rst_n)
    (global_reg & ~dfc_pkg::GLOBAL_MASK) == '0)
    else $error("unused global bits stored");
  a_sync_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    syncControl == $past(global_reg[dfc_pkg::G_AUTOSYNC:0]))
    else $error("sync field output wrong");
  a_mod_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    modulationQuantitySelect[7:6]
    == $past(chan_reg[3][dfc_pkg::C_MOD_HI:dfc_pkg::C_MOD_LO]))
    else $error("modulation select output wrong");
  a_fullscale_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    dacFullScale[1:0]
    == $past(chan_reg[0][dfc_pkg::C_FS_HI:dfc_pkg::C_FS_LO]))
    else $error("full-scale output wrong");
  a_dac_pd_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    dacPowerDown[2] == $past(chan_reg[2][dfc_pkg::C_DAC_PD]))
    else $error("converter power-down output wrong");
  a_matched_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    matchedDelay[1] == $past(chan_reg[1][dfc_pkg::C_MATCHED]))
    else $error("matched delay output wrong");
  a_sine_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    sineSelect[3] == $past(chan_reg[3][dfc_pkg::C_SINE]))
    else $error("sine select output wrong");
endmodule : dfc_channel_control

// ==== test/dfc_host_model.sv ====
// Purpose: host model driving the register port of the function bank
// Assumes: one clock; requests change right after a rising edge
// Notes: the update strobe is a write to the update offset
`timescale 1ns/1ps
module dfc_host_model (
  input wire logic clk,
  output logic [dfc_pkg::ADDR_W-1:0] regAddr,
  output logic [dfc_pkg::DATA_W-1:0] regWdata,
  output logic regWr,
  output logic regRd,
  input wire logic [dfc_pkg::DATA_W-1:0] regRdata
);
  // --------------------------------------------------------------------
  // bus cycles
  // --------------------------------------------------------------------
  // idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // one-cycle write; data inverted after so a missed strobe shows
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    d = data;
    if (addr == dfc_pkg::CHAN_OFS) begin
      d[10] = 1'b0;
    end
    @(posedge clk);
    regAddr <= addr;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regWdata <= ~d;
  endtask : wr

  // one-cycle read; data taken in the following cycle only
  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk);
    regAddr <= addr;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    data = regRdata;
  endtask : rd

  // update strobe applies pending autoclears
  task automatic update();
    wr(dfc_pkg::UPDATE_OFS, 32'h00000001);
  endtask : update
endmodule : dfc_host_model

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the function-control register bank
// Assumes: 200 MHz clock, synchronous active-low reset
// Notes: channel 0 outputs stand for all channels (select resets to all)
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic [31:0] deltaWord;
  logic [31:0] tuningWord;
  logic [7:0] sweepRampRate;
  logic [127:0] phaseAcc;
  logic [127:0] sweepAcc;
  logic [7:0] modSel;
  logic [7:0] dacFullScale;
  logic [3:0] digitalPowerDown;
  logic [3:0] dacPowerDown;
  logic [3:0] matchedDelay;
  logic [3:0] sineSelect;
  logic [3:0] noDwellActive;
  logic [7:0] syncControl;
  int error_cnt = 0;
  int compares = 0;

  dfc_host_model u_host (.clk(clk), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  dfc_channel_control u_dut (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .deltaWord(deltaWord),
    .tuningWord(tuningWord), .sweepRampRate(sweepRampRate),
    .phaseAcc(phaseAcc), .sweepAcc(sweepAcc),
    .modulationQuantitySelect(modSel), .dacFullScale(dacFullScale),
    .digitalPowerDown(digitalPowerDown), .dacPowerDown(dacPowerDown),
    .matchedDelay(matchedDelay), .sineSelect(sineSelect),
    .noDwellActive(noDwellActive), .syncControl(syncControl));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : ticks

  // polls channel 0 each cycle; a one-cycle clear must not slip by
  task automatic saw_zero(input bit ph, output logic seen);
    seen = 1'b0;
    repeat (6) begin
      ticks(1);
      if ((ph ? phaseAcc[31:0] : sweepAcc[31:0]) === 32'h00000000) begin
        seen = 1'b1;
      end
    end
  endtask : saw_zero

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    u_host.rd(dfc_pkg::GLOBAL_OFS, d);
    check(d, 32'h00000000);
    u_host.rd(dfc_pkg::CHAN_OFS, d);
    check(d, 32'h00000300);
    u_host.rd(8'h20, d);
    check(d, 32'h00000000);
    check({24'h000000, dacFullScale}, 32'h000000FF);
    check({20'h00000, digitalPowerDown, dacPowerDown, sineSelect},
      32'h00000000);
    $display("test reset done");
  endtask : t_reset

  // all bits set: reserved bits drop, each field but full scale reaches its output
  task automatic t_fields();
    logic [31:0] d;
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00FFFFFF);
    u_host.rd(dfc_pkg::CHAN_OFS, d);
    check(d, 32'h00C0E3FF);
    ticks(2);
    check({24'h000000, modSel}, 32'h000000FF);
    check({28'h0000000, noDwellActive}, 32'h0000000F);
    check({28'h0000000, digitalPowerDown}, 32'h0000000F);
    check({28'h0000000, dacPowerDown}, 32'h0000000F);
    check({28'h0000000, matchedDelay}, 32'h0000000F);
    check({28'h0000000, sineSelect}, 32'h0000000F);
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00008000);
    ticks(2);
    check({28'h0000000, noDwellActive}, 32'h00000000);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h0000FFFF);
    u_host.rd(dfc_pkg::GLOBAL_OFS, d);
    check(d, 32'h0000F0F3);
    check({24'h000000, syncControl}, 32'h000000F3);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h00000000);
    $display("test fields done");
  endtask : t_fields

  task automatic t_sweep();
    logic [31:0] a;
    logic z;
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00004000);
    ticks(10);
    a = sweepAcc[31:0];
    ticks(10);
    check({31'h0, sweepAcc[31:0] > a}, 32'h00000001);
    u_host.update();
    saw_zero(1'b0, z);
    check({31'h0, z}, 32'h00000000);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h00008000);
    u_host.update();
    saw_zero(1'b0, z);
    check({31'h0, z}, 32'h00000001);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h00000000);
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00004010);
    u_host.update();
    saw_zero(1'b0, z);
    check({31'h0, z}, 32'h00000001);
    $display("test sweep done");
  endtask : t_sweep

  task automatic t_phase();
    logic z;
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00004000);
    u_host.update();
    saw_zero(1'b1, z);
    check({31'h0, z}, 32'h00000000);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h00002000);
    u_host.update();
    saw_zero(1'b1, z);
    check({31'h0, z}, 32'h00000001);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h00000000);
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00004004);
    u_host.update();
    saw_zero(1'b1, z);
    check({31'h0, z}, 32'h00000001);
    $display("test phase done");
  endtask : t_phase

  // held clears keep zero while set, then running resumes
  task automatic t_hold();
    logic [31:0] d;
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h0000400A);
    ticks(4);
    check(sweepAcc[31:0], 32'h00000000);
    check(phaseAcc[31:0], 32'h00000000);
    u_host.rd(dfc_pkg::STATUS_OFS, d);
    check(d, 32'h0000F0FF);
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00004000);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h00005000);
    ticks(4);
    check(sweepAcc[31:0], 32'h00000000);
    check(phaseAcc[31:0], 32'h00000000);
    u_host.wr(dfc_pkg::GLOBAL_OFS, 32'h00000000);
    ticks(4);
    check({31'h0, phaseAcc[31:0] !== 32'h0}, 32'h00000001);
    $display("test hold done");
  endtask : t_hold

  // updates faster than the ramp rate keep reloading, so no step lands
  task automatic t_timer();
    logic [31:0] a;
    logic [31:0] d;
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00006000);
    @(posedge clk);
    sweepRampRate <= 8'h08;
    u_host.update();
    ticks(1);
    a = sweepAcc[31:0];
    repeat (5) u_host.update();
    ticks(1);
    check(sweepAcc[31:0], a);
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00000080);
    ticks(2);
    a = phaseAcc[31:0];
    ticks(4);
    check(phaseAcc[31:0], a);
    u_host.wr(dfc_pkg::SELECT_OFS, 32'h00000002);
    u_host.wr(dfc_pkg::CHAN_OFS, 32'h00000001);
    u_host.rd(dfc_pkg::SELECT_OFS, d);
    check(d, 32'h00000002);
    check({28'h0000000, sineSelect}, 32'h00000002);
    $display("test timer done");
  endtask : t_timer

  // --------------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    deltaWord = 32'h00000001;
    tuningWord = 32'h00000100;
    sweepRampRate = 8'h01;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ticks(1);
    t_reset();
    t_fields();
    t_sweep();
    t_phase();
    t_hold();
    t_timer();
    end_sim();
  end

  // tests take a few hundred cycles; far beyond that is a hang
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : testbench
